// File: logic/bados_sequencer.sv
// Output sequencer: word pacing, restart, sleep, serial shifting of results
// How it works
// - One new result every 81,920 master clock cycles.
// - Results unsettled for six periods after step, gain or trim change.
// - Unipolar results straight binary, bipolar results two's complement.
// - Most significant (sign) bit is shifted out first.
// - Each serial clock falling edge advances to the next lower bit.
// - Every delivered result is 24 bits long.
// - 16-bit variant: 16 data bits then 8 equal flag bits.
// - 20-bit variant: 20 data bits then 4 equal flag bits.
// - Flags zero normally, all ones on overrange.
// - Large overrange: flags set, data may not be clamped.
// - First result after reset or wake may show flags set.
// - Results saturate at top and bottom codes; bipolar mid-scale is zero.
// - Host writes restart bit one then zero to align converters.
// - Filter restarts on first master edge after last write clock falls.
// - Reset clears sleep select, device stays awake.
// - Sleep select one shuts down most of the device.
// - Ready low each period in read mode; high after read, config write or sleep.
// - Reset initialises configuration and returns port to command mode.
`timescale 1ns/10ps
module bados_sequencer
  import bados_pkg::*;
#(
  parameter int unsigned DATA_W = 20,
  parameter int unsigned PERIOD = PERIOD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_in_line,
  input wire logic cfg_write,
  input wire logic read_mode,
  input wire logic [RAW_W-1:0] filter_value,
  input wire logic filter_overrange,
  output logic serial_out_line,
  output logic word_ready_low,
  output logic filter_restart_q,
  output logic sleep_q,
  output logic bipolar_q,
  output logic settled_q,
  output logic period_strobe_q
);
  import bados_pkg::*;

  typedef enum logic [1:0] {PORT_CMD, PORT_CFG, PORT_READ} bados_port_t;

  bados_port_t port_q;
  logic [CNT_W-1:0] period_cnt_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [CFG_BITS-1:0] cfg_shift_q;
  logic [WORD_W-1:0] shift_q;
  logic [SETTLE_CNT_W-1:0] settle_cnt_q;
  logic sclk_q;
  logic first_q;
  logic sclk_fall;
  logic period_done;
  logic cfg_done;
  logic deliver;
  logic [WORD_W-1:0] fmt_word;
  logic [WORD_W-1:0] held_word;
  bados_sample_t sample;
  bados_cfg_t cfg_d;

  // Serial clock is synchronous to the master clock; detect its falling edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
    end
  end
  assign sclk_fall = sclk_q & ~serial_clk;

  assign period_done = (period_cnt_q == CNT_W'(PERIOD - 1)) && !sleep_q;
  assign cfg_done = (port_q == PORT_CFG) && sclk_fall && (bit_cnt_q == LAST_CFG_BIT);
  // A word is only handed to the port when no config write is starting at the same edge
  assign deliver = (port_q == PORT_CMD) && read_mode && period_strobe_q && !sleep_q && !cfg_write;

  // Field at position p arrived p bits before the last one; the last bit is still on the line
  always_comb begin
    cfg_d = '{sleep_sel: serial_in_line,
              restart: cfg_shift_q[CFG_RESTART_POS-1],
              bipolar: cfg_shift_q[CFG_POLARITY_POS-1]};
  end

  // Period counter: held at zero during restart and sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_q <= '0;
    end else if (filter_restart_q || sleep_q || cfg_done) begin
      period_cnt_q <= '0;
    end else if (period_done) begin
      period_cnt_q <= '0;
    end else begin
      period_cnt_q <= period_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_strobe_q <= 1'b0;
    end else begin
      period_strobe_q <= period_done;
    end
  end

  // Configuration bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_q <= 1'b0;
      filter_restart_q <= 1'b0;
      bipolar_q <= 1'b0;
    end else if (cfg_done) begin
      sleep_q <= cfg_d.sleep_sel;
      filter_restart_q <= cfg_d.restart;
      bipolar_q <= cfg_d.bipolar;
    end
  end

  // Settling tracker: six full periods after any restart, wake or config write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_q <= '0;
      settled_q <= 1'b0;
    end else if (cfg_done || filter_restart_q || sleep_q) begin
      settle_cnt_q <= '0;
      settled_q <= 1'b0;
    end else if (period_done && !settled_q) begin
      settle_cnt_q <= settle_cnt_q + SETTLE_CNT_W'(1);
      settled_q <= (settle_cnt_q == SETTLE_CNT_W'(SETTLE_PERIODS - 1));
    end
  end

  // First result after reset or wake carries forced flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
    end else if (sleep_q) begin
      first_q <= 1'b1;
    end else if (period_done) begin
      first_q <= 1'b0;
    end
  end

  assign sample = '{valid: period_done, overrange: filter_overrange, value: filter_value};

  bados_formatter #(
    .DATA_W(DATA_W)
  ) u_fmt (
    .clock(clock),
    .rst_n(rst_n),
    .bipolar(bipolar_q),
    .force_flags(first_q),
    .sample(sample),
    .word_q(fmt_word)
  );

  bados_hold_reg #(
    .WIDTH(WORD_W)
  ) u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .load(period_strobe_q),
    .load_word(fmt_word),
    .held_word(held_word)
  );

  // Serial port state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_q <= PORT_CMD;
      bit_cnt_q <= '0;
    end else begin
      case (port_q)
        PORT_CMD: begin
          bit_cnt_q <= '0;
          if (cfg_write) begin
            port_q <= PORT_CFG;
          end else if (deliver) begin
            port_q <= PORT_READ;
          end
        end
        PORT_CFG: begin
          if (sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
            if (bit_cnt_q == LAST_CFG_BIT) begin
              port_q <= PORT_CMD;
            end
          end
        end
        PORT_READ: begin
          if (sleep_q) begin
            port_q <= PORT_CMD;
          end else if (sclk_fall) begin
            bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
            if (bit_cnt_q == LAST_OUT_BIT) begin
              port_q <= PORT_CMD;
            end
          end
        end
        default: begin
          port_q <= PORT_CMD;
        end
      endcase
    end
  end

  // Configuration input shift on each falling serial clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_shift_q <= CFG_RESET;
    end else if (port_q == PORT_CFG && sclk_fall) begin
      cfg_shift_q <= {cfg_shift_q[CFG_BITS-2:0], serial_in_line};
    end
  end

  // Output shift register; loaded in the same cycle as the hold register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (deliver) begin
      shift_q <= fmt_word;
    end else if (port_q == PORT_READ && sclk_fall) begin
      shift_q <= {shift_q[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_line <= 1'b0;
    end else if (deliver) begin
      serial_out_line <= fmt_word[WORD_W-1];
    end else if (port_q == PORT_READ && sclk_fall) begin
      serial_out_line <= shift_q[WORD_W-2];
    end
  end

  // Ready indicator, active low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_ready_low <= 1'b1;
    end else if (sleep_q || port_q == PORT_CFG) begin
      word_ready_low <= 1'b1;
    end else if (deliver) begin
      word_ready_low <= 1'b0;
    end else if (port_q == PORT_READ && sclk_fall && bit_cnt_q == LAST_OUT_BIT) begin
      word_ready_low <= 1'b1;
    end
  end

  a_period_pace: assert property (@(posedge clock) disable iff (!rst_n)
    period_done |=> !period_done [*8]) else $error("period strobe too close");
  a_sleep_idle: assert property (@(posedge clock) disable iff (!rst_n)
    sleep_q |-> period_cnt_q == '0 ##1 !period_strobe_q) else $error("counting while asleep");
  a_ready_sleep: assert property (@(posedge clock) disable iff (!rst_n)
    sleep_q |=> word_ready_low) else $error("ready low in sleep");
  a_msb_first: assert property (@(posedge clock) disable iff (!rst_n)
    deliver |=> serial_out_line == fmt_word[WORD_W-1])
    else $error("msb not first");
  a_bit_advance: assert property (@(posedge clock) disable iff (!rst_n)
    (port_q == PORT_READ && sclk_fall && !sleep_q) |=> serial_out_line == $past(shift_q[WORD_W-2]))
    else $error("bit did not advance");
  a_hold_stable: assert property (@(posedge clock) disable iff (!rst_n)
    !period_strobe_q |=> $stable(held_word)) else $error("held word changed");
  a_restart_hold: assert property (@(posedge clock) disable iff (!rst_n)
    filter_restart_q |=> period_cnt_q == '0) else $error("filter ran during restart");
  a_flags_equal: assert property (@(posedge clock) disable iff (!rst_n)
    period_strobe_q |-> fmt_word[WORD_W-DATA_W-1:0] == '0 || &fmt_word[WORD_W-DATA_W-1:0])
    else $error("flag bits differ");
  a_unsettled: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_done |=> !settled_q) else $error("settled after config write");

  c_read_word: cover property (@(posedge clock) disable iff (!rst_n)
    port_q == PORT_READ && sclk_fall && bit_cnt_q == LAST_OUT_BIT);
  c_cfg_write: cover property (@(posedge clock) disable iff (!rst_n) cfg_done);
  c_settled: cover property (@(posedge clock) disable iff (!rst_n) $rose(settled_q));
endmodule : bados_sequencer

// File: logic/bados_pkg.sv
// Shared constants and carrier types for the bridge converter output sequencer
package bados_pkg;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned RAW_W = 20;
  localparam int unsigned PERIOD_CYCLES = 81920;
  localparam int unsigned SETTLE_PERIODS = 6;
  localparam int unsigned SETTLE_CYCLES = PERIOD_CYCLES * SETTLE_PERIODS;
  localparam int unsigned CFG_BITS = 24;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned BIT_CNT_W = 5;
  localparam int unsigned SETTLE_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_CFG_BIT = 5'h17;
  localparam logic [BIT_CNT_W-1:0] LAST_OUT_BIT = 5'h17;
  localparam int unsigned CFG_SLEEP_POS = 0;
  localparam int unsigned CFG_RESTART_POS = 1;
  localparam int unsigned CFG_POLARITY_POS = 2;
  localparam logic [CFG_BITS-1:0] CFG_RESET = 24'h000000;

  typedef struct packed {
    logic sleep_sel;
    logic restart;
    logic bipolar;
  } bados_cfg_t;

  typedef struct packed {
    logic valid;
    logic overrange;
    logic [RAW_W-1:0] value;
  } bados_sample_t;
endpackage : bados_pkg

// File: logic/bados_hold_reg.sv
// Output holding register for one completed result word
`timescale 1ns/10ps
module bados_hold_reg #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_word,
  output logic [WIDTH-1:0] held_word
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_word <= '0;
    end else if (load) begin
      held_word <= load_word;
    end
  end
endmodule : bados_hold_reg

// File: logic/bados_formatter.sv
// Formats a raw filter result into a 24-bit word with replicated flags
`timescale 1ns/10ps
module bados_formatter
  import bados_pkg::*;
#(
  parameter int unsigned DATA_W = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bipolar,
  input wire logic force_flags,
  input wire bados_pkg::bados_sample_t sample,
  output logic [WORD_W-1:0] word_q
);
  localparam int unsigned FLAG_W = WORD_W - DATA_W;
  logic [DATA_W-1:0] data;
  logic flag;

  always_comb begin
    data = sample.value[RAW_W-1 -: DATA_W];
    // Straight binary to two's complement is a flip of the top bit
    if (bipolar) begin
      data[DATA_W-1] = ~data[DATA_W-1];
    end
    flag = sample.overrange | force_flags;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= '0;
    end else if (sample.valid) begin
      word_q <= {data, {FLAG_W{flag}}};
    end
  end
endmodule : bados_formatter

// File: verification/bados_host.sv
// Host model that shifts configuration words in and result words out
`timescale 1ns/10ps
module bados_host (
  input wire logic clock,
  input wire logic serial_out_line,
  input wire logic serial_out_alt,
  input wire logic word_ready_low,
  output logic serial_clk,
  output logic serial_in_line,
  output logic cfg_write
);
  initial begin
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
    cfg_write = 1'b0;
  end
  task automatic step;
    @(posedge clock);
    #2;
  endtask : step
  task automatic write_cfg(input logic [23:0] w);
    cfg_write = 1'b1;
    step();
    cfg_write = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_in_line = w[i];
      serial_clk = 1'b1;
      step();
      serial_clk = 1'b0;
      step();
    end
    // Line is left at a changed level so stale data never looks valid
    serial_in_line = ~w[0];
    step();
  endtask : write_cfg
  task automatic read_word(input int slow, output logic [23:0] w, output logic [23:0] w_alt, output bit ok);
    int n;
    n = 0;
    while (word_ready_low !== 1'b0 && n < 1000) begin
      step();
      n++;
    end
    ok = (word_ready_low === 1'b0);
    w = 'x;
    w_alt = 'x;
    for (int i = 23; i >= 0 && ok; i--) begin
      w[i] = serial_out_line;
      w_alt[i] = serial_out_alt;
      serial_clk = 1'b1;
      repeat (slow + 1) step();
      serial_clk = 1'b0;
      step();
      step();
    end
  endtask : read_word
endmodule : bados_host

// File: verification/tb_top.sv
// Self-checking bench for the output sequencer
`timescale 1ns/10ps
module tb_top;
  import bados_pkg::*;
  localparam int PER = 128;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic read_mode = 1'b1;
  logic filter_overrange = 1'b0;
  logic [RAW_W-1:0] filter_value = '0;
  logic serial_clk, serial_in_line, cfg_write, serial_out_line, word_ready_low;
  logic serial_out_alt;
  logic filter_restart_q, sleep_q, bipolar_q, settled_q, period_strobe_q;
  int mismatches = 0;
  int total_checks = 0;
  bados_host host (.clock(clock), .serial_out_line(serial_out_line), .serial_out_alt(serial_out_alt),
    .word_ready_low(word_ready_low),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line), .cfg_write(cfg_write));
  bados_sequencer #(.DATA_W(20), .PERIOD(PER)) dut (.clock(clock), .rst_n(rst_n),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line), .cfg_write(cfg_write),
    .read_mode(read_mode), .filter_value(filter_value), .filter_overrange(filter_overrange),
    .serial_out_line(serial_out_line), .word_ready_low(word_ready_low),
    .filter_restart_q(filter_restart_q), .sleep_q(sleep_q), .bipolar_q(bipolar_q),
    .settled_q(settled_q), .period_strobe_q(period_strobe_q));
  // 16-bit variant fed the same stimulus, read in step with the main instance
  bados_sequencer #(.DATA_W(16), .PERIOD(PER)) dut_b (.clock(clock), .rst_n(rst_n),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line), .cfg_write(cfg_write),
    .read_mode(read_mode), .filter_value(filter_value), .filter_overrange(filter_overrange),
    .serial_out_line(serial_out_alt), .word_ready_low(), .filter_restart_q(), .sleep_q(), .bipolar_q(),
    .settled_q(), .period_strobe_q());
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_strobe(input int lim, output int n, input bit must);
    n = 0;
    do begin
      @(posedge clock);
      #2;
      n++;
    end while (period_strobe_q !== 1'b1 && n < lim);
    if (must && period_strobe_q !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_strobe
  // Empties a pending word so the port is back in command state
  task automatic drain;
    logic [23:0] w;
    logic [23:0] wb;
    bit ok;
    if (word_ready_low === 1'b0) host.read_word(0, w, wb, ok);
  endtask : drain
  task automatic cfg(input logic [23:0] w);
    drain();
    host.write_cfg(w);
  endtask : cfg
  task automatic get_word(input logic [19:0] v, input logic ovr, input int slow, input logic [23:0] exp);
    logic [23:0] w;
    logic [23:0] wb;
    bit ok;
    int n;
    filter_value = v;
    filter_overrange = ovr;
    drain();
    wait_strobe(3 * PER, n, 1'b1);
    host.read_word(slow, w, wb, ok);
    if (!ok) begin
      mismatches++;
      wrap_up();
    end
    check("word", w, exp);
    check("word16", wb, {exp[23:8], {8{exp[0]}}});
    check("ready after read", word_ready_low, 1'b1);
  endtask : get_word
  task automatic t_period;
    int n;
    wait_strobe(3 * PER, n, 1'b1);
    wait_strobe(3 * PER, n, 1'b1);
    check("period", 24'(n), 24'(PER));
  endtask : t_period
  task automatic t_codes(input logic bip);
    logic [19:0] v [4] = '{20'hFFFFF, 20'h00000, 20'h80000, 20'h12345};
    for (int i = 0; i < 4; i++) begin
      get_word(v[i], i == 3, i % 2, {v[i] ^ {bip, 19'h0}, {4{i == 3}}});
    end
  endtask : t_codes
  task automatic t_restart;
    int n;
    cfg(24'h000002);
    check("restart bit", filter_restart_q, 1'b1);
    wait_strobe(2 * PER, n, 1'b0);
    check("held off", {period_strobe_q, word_ready_low}, 2'b01);
    cfg(24'h000000);
    check("unsettled", settled_q, 1'b0);
    wait_strobe(2 * PER, n, 1'b1);
    check("restart phase", n >= PER - 3 && n <= PER + 3, 1'b1);
    repeat (4) wait_strobe(2 * PER, n, 1'b1);
    check("five periods", settled_q, 1'b0);
    repeat (2) wait_strobe(2 * PER, n, 1'b1);
    check("seven periods", settled_q, 1'b1);
  endtask : t_restart
  task automatic t_sleep;
    int n;
    cfg(24'h000001);
    check("sleep bit", sleep_q, 1'b1);
    wait_strobe(2 * PER, n, 1'b0);
    check("asleep", {period_strobe_q, word_ready_low}, 2'b01);
    cfg(24'h000002);
    check("awake", {sleep_q, filter_restart_q}, 2'b01);
    cfg(24'h000000);
    get_word(20'h00F0F, 1'b0, 0, {20'h00F0F, 4'hF});
  endtask : t_sleep
  task automatic t_reset;
    int n;
    read_mode = 1'b0;
    wait_strobe(3 * PER, n, 1'b1);
    @(posedge clock);
    #2;
    check("no read mode", word_ready_low, 1'b1);
    read_mode = 1'b1;
    cfg(24'h000004);
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #2;
    rst_n = 1'b1;
    check("mid reset", {sleep_q, filter_restart_q, bipolar_q, word_ready_low}, 4'b0001);
    get_word(20'h13579, 1'b0, 0, {20'h13579, 4'hF});
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clock);
    #2;
    rst_n = 1'b1;
    check("reset cfg", {sleep_q, filter_restart_q, bipolar_q}, 3'b000);
    check("reset ready", word_ready_low, 1'b1);
    get_word(20'hABCDE, 1'b0, 0, {20'hABCDE, 4'hF});
    t_period();
    t_codes(1'b0);
    cfg(24'h000004);
    check("bipolar bit", bipolar_q, 1'b1);
    t_codes(1'b1);
    t_restart();
    t_sleep();
    t_reset();
    wrap_up();
  end
endmodule : tb_top
